// ==== common/sram_port_pkg.sv ====
// Package: pin bundles, command codes and timing counts for the latched-address SRAM controller
package sram_port_pkg;

   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned ADDR_W          = 12;
   localparam int unsigned DEPTH           = 4096;

   // Timing figures in ns, as printed for the slowest grade
   localparam int unsigned MIN_IDL_TIM_NS    = 150;
   localparam int unsigned CYC_LOW_NS        = 350;
   localparam int unsigned ADDR_SETUP_NS     = 20;
   localparam int unsigned ADDR_HOLD_NS      = 50;
   localparam int unsigned MIN_STOR_PULSE_NS = 150;
   localparam int unsigned BIT_SETUP_TIM_NS  = 150;
   localparam int unsigned BIT_HOLD_TIM_NS   = 0;
   localparam int unsigned ACCESS_NS         = 350;
   localparam int unsigned OUT_OFF_NS        = 100;

   // Least times round up to whole cycles, never below one
   function automatic int unsigned cyc_up(input int unsigned ns);
      int unsigned c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int unsigned MIN_IDL_TIM_CYC    = cyc_up(MIN_IDL_TIM_NS);
   localparam int unsigned CYC_LOW_CYC        = cyc_up(CYC_LOW_NS);
   localparam int unsigned ADDR_SETUP_CYC     = cyc_up(ADDR_SETUP_NS);
   localparam int unsigned ADDR_HOLD_CYC      = cyc_up(ADDR_HOLD_NS);
   localparam int unsigned MIN_STOR_PULSE_CYC = cyc_up(MIN_STOR_PULSE_NS);
   localparam int unsigned BIT_SETUP_TIM_CYC  = cyc_up(BIT_SETUP_TIM_NS);
   localparam int unsigned BIT_HOLD_TIM_CYC   = cyc_up(BIT_HOLD_TIM_NS);
   localparam int unsigned ACCESS_CYC         = cyc_up(ACCESS_NS);
   localparam int unsigned OUT_OFF_CYC        = cyc_up(OUT_OFF_NS);

   localparam int unsigned CNT_W = 8;

   typedef enum logic [1:0] {
      CMD_READ  = 2'h0,
      CMD_WRITE = 2'h1,
      CMD_RMW   = 2'h2
   } cmd_t;

   typedef struct packed {
      cmd_t              cmd;
      logic [ADDR_W-1:0] addr;
      logic              wbit;
      logic              burst;
   } req_t;

   typedef struct packed {
      logic              cyc_strb_n;
      logic              stor_strb_n;
      logic              out_drv_n;
      logic [ADDR_W-1:0] addr;
      logic              bit_o;
      logic              bit_oe;
   } pins_t;

endpackage

// ==== core/step_timer.sv ====
// Module: down-counting phase timer that flags the last cycle of a phase
`timescale 1ns/1ps
module step_timer (
   input  wire logic                            core_clk,
   input  wire logic                            reset_n,
   input  wire logic                            load,
   input  wire logic [sram_port_pkg::CNT_W-1:0] load_val,
   output logic                                 done
);
   import sram_port_pkg::*;

   logic [CNT_W-1:0] cnt_ff;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // Done in the last cycle of a phase, so a load of c-1 spans c cycles.
   // Load is kept out of this term: the sequencer derives load from done.
   assign done = (cnt_ff == '0);

endmodule // step_timer

// ==== core/sram_port_ctrl.sv ====
// Module: controller that drives a latched-address 4096 x 1 SRAM through its strobe pins
// Contract
// RL1: Device latches address on cycle strobe fall; latch governs whole cycle.
// RL2: Address set up before and held after cycle strobe fall.
// RL3: Read output first undefined, valid only after access time.
// RL4: Store strobe stays high through a whole read cycle; after a burst write it stays low until the access phase.
// RL5: Cycle strobe rise turns device output off; next cycle after that.
// RL6: Output-drive high keeps device output off regardless of other strobes.
// RL7: Write starts at cycle strobe fall; bit stored while both strobes low.
// RL8: Output-drive held high throughout a plain write.
// RL9: Write bit setup and hold around store strobe rise, else cycle rise.
// RL10: Write ends at first rise of store or cycle strobe.
// RL11: Cycle strobe held high at least minimum idle time between cycles.
// RL12: Consecutive writes may keep store strobe low, framed by cycle strobe.
// RL13: Never lower cycle and output-drive before store strobe in a write.
// RL14: Read-modify-write reads first, then store pulse of minimum width.
// RL15: Output-drive raised while store low; controller drives the bit.
// RL16: Written bit readable again after store strobe rises, cycle still low.
// RL17: Any mix of reads and writes allowed while cycle strobe low.
// RL18: Retention: cycle strobe high, output-drive high, other pins firm.
// RL19: After supply recovery wait one minimum idle time before a cycle.
// RL20: Array holds 4096 one-bit locations.
// RL21: Shared bidirectional data pin, tristated by the device.
// RL22: Address latch is 12 bits wide.
`timescale 1ns/1ps
module sram_port_ctrl (
   input  wire logic                              core_clk,
   input  wire logic                              reset_n,
   input  wire logic                              req_valid,
   input  wire sram_port_pkg::req_t               req,
   output logic                                   req_ready,
   output logic                                   rsp_valid,
   output logic                                   rsp_bit,
   input  wire logic                              retain,
   input  wire logic                              supply_ok,
   output sram_port_pkg::pins_t                   pins,
   input  wire logic                              bit_i
);
   import sram_port_pkg::*;

   typedef enum logic [3:0] {
      ST_POWER  = 4'b0000,
      ST_IDLE   = 4'b0001,
      ST_SETUP  = 4'b0011,
      ST_HOLD   = 4'b0010,
      ST_ACCESS = 4'b0110,
      ST_STORE  = 4'b0111,
      ST_BHOLD  = 4'b0101,
      ST_CLOSE  = 4'b0100,
      ST_GAP    = 4'b1100,
      ST_RETAIN = 4'b1101
   } state_t;

   state_t             state_ff;
   state_t             nxt_state;
   req_t               req_ff;
   pins_t              pins_ff;
   logic               req_ready_ff;
   logic               rsp_valid_ff;
   logic               rsp_bit_ff;
   logic               burst_ff;
   logic               tmr_load;
   logic [CNT_W-1:0]   tmr_val;
   logic               tmr_done;

   function automatic logic [CNT_W-1:0] cnt(input int unsigned c);
      return CNT_W'(c - 1);
   endfunction

   step_timer u_timer (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   assign pins      = pins_ff;
   assign req_ready = req_ready_ff;
   assign rsp_valid = rsp_valid_ff;
   assign rsp_bit   = rsp_bit_ff;

   // Phase sequencing
   always_comb begin
      nxt_state = state_ff;
      tmr_load  = 1'b0;
      tmr_val   = '0;
      case (state_ff)
         ST_POWER: begin
            if (supply_ok && !retain) begin
               nxt_state = ST_GAP; // RL19
               tmr_load  = 1'b1;
               tmr_val   = cnt(MIN_IDL_TIM_CYC);
            end
         end
         ST_IDLE: begin
            if (retain || !supply_ok) begin
               nxt_state = ST_RETAIN; // RL18
            end else if (req_valid) begin
               nxt_state = ST_SETUP; // RL2
               tmr_load  = 1'b1;
               tmr_val   = cnt(ADDR_SETUP_CYC);
            end
         end
         ST_SETUP: begin
            if (tmr_done) begin
               nxt_state = ST_HOLD; // RL1
               tmr_load  = 1'b1;
               tmr_val   = cnt(ADDR_HOLD_CYC);
            end
         end
         ST_HOLD: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (req_ff.cmd == CMD_WRITE) begin
                  nxt_state = ST_STORE; // RL7
                  tmr_val   = cnt(BIT_SETUP_TIM_CYC > MIN_STOR_PULSE_CYC ?
                                  BIT_SETUP_TIM_CYC : MIN_STOR_PULSE_CYC);
               end else begin
                  nxt_state = ST_ACCESS; // RL3
                  tmr_val   = cnt(ACCESS_CYC);
               end
            end
         end
         ST_ACCESS: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (req_ff.cmd == CMD_RMW) begin
                  nxt_state = ST_STORE; // RL14
                  tmr_val   = cnt(MIN_STOR_PULSE_CYC);
               end else begin
                  nxt_state = ST_CLOSE;
                  tmr_val   = cnt(CYC_LOW_CYC);
               end
            end
         end
         ST_STORE: begin
            if (tmr_done) begin
               nxt_state = ST_BHOLD; // RL9
               tmr_load  = 1'b1;
               tmr_val   = cnt(BIT_HOLD_TIM_CYC);
            end
         end
         ST_BHOLD: begin
            if (tmr_done) begin
               nxt_state = ST_CLOSE;
               tmr_load  = 1'b1;
               tmr_val   = cnt(OUT_OFF_CYC);
            end
         end
         ST_CLOSE: begin
            if (tmr_done) begin
               nxt_state = ST_GAP; // RL11
               tmr_load  = 1'b1;
               tmr_val   = cnt(MIN_IDL_TIM_CYC);
            end
         end
         ST_GAP: begin
            if (tmr_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_RETAIN: begin
            if (!retain && supply_ok) begin
               nxt_state = ST_GAP; // RL19
               tmr_load  = 1'b1;
               tmr_val   = cnt(MIN_IDL_TIM_CYC);
            end
         end
         default: nxt_state = ST_POWER;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_POWER;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Request capture; burst keeps store strobe low across back-to-back writes
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_ff       <= '0;
         req_ready_ff <= 1'b0;
         burst_ff     <= 1'b0;
      end else begin
         req_ready_ff <= (nxt_state == ST_IDLE) && !retain && supply_ok;
         if (state_ff == ST_IDLE && nxt_state == ST_SETUP) begin
            req_ff <= req;
         end
         if (state_ff == ST_BHOLD && tmr_done) begin
            burst_ff <= req_ff.cmd == CMD_WRITE && req_ff.burst; // RL12
         end else if (state_ff == ST_IDLE && nxt_state == ST_SETUP) begin
            burst_ff <= burst_ff && req.cmd == CMD_WRITE;
         end else if (state_ff == ST_IDLE || state_ff == ST_RETAIN) begin
            burst_ff <= burst_ff && !retain;
         end
      end
   end

   // Pin drive, all registered
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         pins_ff <= '{cyc_strb_n: 1'b1, stor_strb_n: 1'b1, out_drv_n: 1'b1,
                      addr: '0, bit_o: 1'b0, bit_oe: 1'b0};
      end else begin
         case (nxt_state)
            ST_SETUP: begin
               pins_ff.addr       <= req.addr;
               pins_ff.bit_o      <= req.wbit;
               pins_ff.cyc_strb_n <= 1'b1;
            end
            ST_HOLD: begin
               pins_ff.cyc_strb_n <= 1'b0; // RL1
               pins_ff.bit_oe     <= req_ff.cmd == CMD_WRITE;
            end
            ST_ACCESS: begin
               pins_ff.stor_strb_n <= 1'b1; // RL4
               pins_ff.out_drv_n   <= 1'b0; // RL13
            end
            ST_STORE: begin
               // Drive off in the same cycle that store falls, so no bus fight on the pin
               pins_ff.out_drv_n   <= 1'b1; // RL8 RL15
               pins_ff.stor_strb_n <= 1'b0; // RL7
               pins_ff.bit_oe      <= 1'b1;
            end
            ST_BHOLD: begin
               pins_ff.stor_strb_n <= burst_ff ? 1'b0 : 1'b1; // RL10 RL12
            end
            ST_CLOSE: begin
               pins_ff.stor_strb_n <= (req_ff.cmd == CMD_WRITE && req_ff.burst)
                                      ? 1'b0 : 1'b1;
               // Bit held through close so a burst write ends on cycle rise
               pins_ff.bit_oe <= req_ff.cmd == CMD_WRITE && req_ff.burst;
               pins_ff.out_drv_n  <= (req_ff.cmd == CMD_READ) ? 1'b0 : 1'b1; // RL16
            end
            ST_GAP, ST_IDLE: begin
               pins_ff.cyc_strb_n <= 1'b1; // RL5 RL11
               pins_ff.out_drv_n  <= 1'b1; // RL6
               pins_ff.bit_oe     <= 1'b0;
               if (!burst_ff) begin
                  pins_ff.stor_strb_n <= 1'b1;
               end
            end
            default: begin
               pins_ff.cyc_strb_n  <= 1'b1; // RL18
               pins_ff.out_drv_n   <= 1'b1;
               pins_ff.stor_strb_n <= 1'b1;
               pins_ff.bit_oe      <= 1'b0;
               pins_ff.addr        <= '0;
               pins_ff.bit_o       <= 1'b0;
            end
         endcase
      end
   end

   // Read bit sampled at end of access, after output turns valid
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid_ff <= 1'b0;
         rsp_bit_ff   <= 1'b0;
      end else begin
         rsp_valid_ff <= 1'b0;
         if (state_ff == ST_ACCESS && tmr_done) begin
            rsp_valid_ff <= 1'b1; // RL3 RL17
            rsp_bit_ff   <= bit_i;
         end else if (state_ff == ST_BHOLD && tmr_done && req_ff.cmd == CMD_WRITE) begin
            // Read-modify-write already answered with its read bit
            rsp_valid_ff <= 1'b1;
            rsp_bit_ff   <= pins_ff.bit_o;
         end
      end
   end

endmodule // sram_port_ctrl

// ==== testbench/sram_port_props.sv ====
// Checker: pin timing properties of the SRAM controller
`timescale 1ns/1ps
module sram_port_props (
   input wire logic                 core_clk,
   input wire logic                 reset_n,
   input wire logic                 req_ready,
   input wire logic                 retain,
   input wire logic                 supply_ok,
   input wire sram_port_pkg::pins_t pins
);
   import sram_port_pkg::*;
   logic [7:0] hi_ff;
   logic [7:0] lo_ff;
   logic [7:0] ok_ff;
   // Saturating run lengths of strobe levels and of good supply
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) hi_ff <= 8'h00;
      else if (!pins.cyc_strb_n) hi_ff <= 8'h00;
      else if (hi_ff != 8'hff) hi_ff <= hi_ff + 8'h01;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) lo_ff <= 8'h00;
      else if (pins.stor_strb_n) lo_ff <= 8'h00;
      else if (lo_ff != 8'hff) lo_ff <= lo_ff + 8'h01;
   end
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) ok_ff <= 8'h00;
      else if (!supply_ok || retain) ok_ff <= 8'h00;
      else if (ok_ff != 8'hff) ok_ff <= ok_ff + 8'h01;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_open;
      $fell(pins.cyc_strb_n);
   endsequence
   sequence s_stor_end;
      $rose(pins.stor_strb_n);
   endsequence
   property p_addr_hold;
      s_open |-> $stable(pins.addr)[*5];
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address moved near cycle start");
   property p_no_clash;
      !pins.out_drv_n |-> pins.stor_strb_n && !pins.bit_oe;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("output on during store");
   property p_oe_drv;
      pins.bit_oe |-> pins.out_drv_n;
   endproperty
   a_oe_drv: assert property (p_oe_drv) else $error("bit driven with output on");
   property p_idle;
      s_open |-> hi_ff >= MIN_IDL_TIM_CYC;
   endproperty
   a_idle: assert property (p_idle) else $error("cycle strobe idle too short");
   property p_stor_pulse;
      s_stor_end |-> lo_ff >= MIN_STOR_PULSE_CYC;
   endproperty
   a_stor_pulse: assert property (p_stor_pulse) else $error("store pulse too short");
   property p_bit_hold;
      s_stor_end |-> $past(pins.bit_oe) && $stable(pins.bit_o);
   endproperty
   a_bit_hold: assert property (p_bit_hold) else $error("bit not held at store end");
   property p_power;
      $rose(req_ready) |-> ok_ff >= MIN_IDL_TIM_CYC;
   endproperty
   a_power: assert property (p_power) else $error("ready before supply settle");
   property p_retain;
      retain && pins.cyc_strb_n && !req_ready |=>
         pins.cyc_strb_n && pins.out_drv_n && !pins.bit_oe;
   endproperty
   a_retain: assert property (p_retain) else $error("pins active in retention");
endmodule // sram_port_props
bind sram_port_ctrl sram_port_props chk_u (.core_clk(core_clk), .reset_n(reset_n),
   .req_ready(req_ready), .retain(retain), .supply_ok(supply_ok), .pins(pins));

// ==== testbench/sram_dev_model.sv ====
// Behavioural model of the 4096 x 1 latched-address static RAM
`timescale 1ns/1ps
module sram_dev_model (
   input  wire logic                             cyc_strb_n,
   input  wire logic                             stor_strb_n,
   input  wire logic                             out_drv_n,
   input  wire logic [sram_port_pkg::ADDR_W-1:0] addr,
   input  wire logic                             bit_w,
   input  wire logic                             late,
   output logic                                  q,
   output logic                                  q_oe
);
   import sram_port_pkg::*;
   logic              mem [DEPTH];
   logic [ADDR_W-1:0] lat_addr;
   logic              vld = 1'b0;
   logic              wr_bit;
   always @(negedge cyc_strb_n) begin
      lat_addr = addr;
      vld = 1'b0;
      #(late ? 380 : 200);
      if (!cyc_strb_n) vld = 1'b1;
   end
   always @* if (!cyc_strb_n && !stor_strb_n) wr_bit = bit_w;
   // First rising strobe ends the write
   always @(posedge stor_strb_n or posedge cyc_strb_n) begin
      if (stor_strb_n != cyc_strb_n) mem[lat_addr] = wr_bit;
   end
   assign q_oe = !cyc_strb_n && !out_drv_n && stor_strb_n;
   // Before valid time the pin shows the wrong level
   assign q = vld ? mem[lat_addr] : ~mem[lat_addr];
endmodule // sram_dev_model

// ==== testbench/tb_top.sv ====
// Testbench: SRAM controller against the RAM model
`timescale 1ns/1ps
module tb_top;
   import sram_port_pkg::*;
   logic  core_clk, reset_n, req_valid, req_ready, rsp_valid, rsp_bit;
   logic  retain, supply_ok, bit_w, last_ff = 1'b0, q, q_oe, late, r;
   req_t  req;
   pins_t pins;
   int    fail_count = 0;
   int    check_count = 0;
   sram_port_ctrl dut_u (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_bit(rsp_bit),
      .retain(retain), .supply_ok(supply_ok), .pins(pins), .bit_i(bit_w));
   sram_dev_model dev_u (.cyc_strb_n(pins.cyc_strb_n), .stor_strb_n(pins.stor_strb_n),
      .out_drv_n(pins.out_drv_n), .addr(pins.addr), .bit_w(bit_w), .late(late),
      .q(q), .q_oe(q_oe));
   // Undriven pin shows the inverse of its last level
   assign bit_w = pins.bit_oe ? pins.bit_o : (q_oe ? q : ~last_ff);
   always @(posedge core_clk) last_ff <= bit_w;
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic got, input logic exp, input string msg);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
   endtask
   task automatic do_req(input cmd_t c, input logic [ADDR_W-1:0] a, input logic w,
                         input logic b, output logic got);
      int n;
      n = 0;
      @(negedge core_clk);
      req_valid = 1'b1;
      req = '{cmd: c, addr: a, wbit: w, burst: b};
      wait_ready();
      @(negedge core_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      got = rsp_bit;
      chk(rsp_valid, 1'b1, "no response");
   endtask
   task automatic t_power();
      int n;
      n = 0;
      repeat (30) @(negedge core_clk);
      chk(req_ready, 1'b0, "ready without supply");
      supply_ok = 1'b1;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      chk(n >= MIN_IDL_TIM_CYC, 1'b1, "ready too soon");
   endtask
   task automatic t_rw();
      do_req(CMD_WRITE, 12'h000, 1'b1, 1'b0, r);
      chk(r, 1'b1, "write echo");
      do_req(CMD_WRITE, 12'hfff, 1'b0, 1'b0, r);
      for (int i = 0; i < 2; i++) begin
         late = i[0];
         do_req(CMD_READ, 12'h000, 1'b0, 1'b0, r);
         chk(r, 1'b1, "read low corner");
         do_req(CMD_READ, 12'hfff, 1'b1, 1'b0, r);
         chk(r, 1'b0, "read high corner");
      end
   endtask
   task automatic t_rmw();
      do_req(CMD_RMW, 12'h000, 1'b0, 1'b0, r);
      chk(r, 1'b1, "rmw old bit");
      do_req(CMD_READ, 12'h000, 1'b1, 1'b0, r);
      chk(r, 1'b0, "rmw new bit");
   endtask
   task automatic t_burst();
      do_req(CMD_WRITE, 12'h00a, 1'b1, 1'b1, r);
      chk(pins.stor_strb_n, 1'b0, "store released in burst");
      do_req(CMD_WRITE, 12'h00b, 1'b0, 1'b0, r);
      do_req(CMD_READ, 12'h00a, 1'b0, 1'b0, r);
      chk(r, 1'b1, "burst first bit");
      do_req(CMD_READ, 12'h00b, 1'b1, 1'b0, r);
      chk(r, 1'b0, "burst second bit");
   endtask
   task automatic t_retain();
      wait_ready();
      retain = 1'b1;
      repeat (20) @(negedge core_clk);
      chk(req_ready, 1'b0, "ready in retention");
      chk(pins.cyc_strb_n & pins.out_drv_n, 1'b1, "strobes in retention");
      retain = 1'b0;
      do_req(CMD_READ, 12'hfff, 1'b0, 1'b0, r);
      chk(r, 1'b0, "data after retention");
   endtask
   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req = '0;
      retain = 1'b0;
      supply_ok = 1'b0;
      late = 1'b0;
      repeat (2) @(negedge core_clk);
      reset_n = 1'b1;
      t_power();
      t_rw();
      t_rmw();
      t_burst();
      t_retain();
      final_report();
   end
   initial begin
      #60000;
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      final_report();
   end
endmodule // tb_top
